/* File: uvp_pkg.sv */
package uvp_pkg;
   localparam int CLK_NS = 25;
   localparam int US_NS = 1000;
   localparam int TICK_CYC = US_NS / CLK_NS;
   localparam int PULSE_US_DEF = 1000;
   localparam int OVP_FACTOR = 3;
   localparam int MAX_TRIES = 25;
   localparam int SETUP_US = 2;
   localparam int VALID_NS = 150;
   localparam int VALID_CYC = (VALID_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLOAT_NS = 130;
   localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_STG = 2;
   localparam int RD_SAMPLE = VALID_CYC + SYNC_STG + 1;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   localparam int LEN_W = 17;
   localparam int TRY_W = 5;
   localparam int CYC_W = 4;
   localparam int CNT_W = 24;

   typedef enum logic [1:0] {
      OP_PROG = 2'h0,
      OP_CMP = 2'h1,
      OP_ID = 2'h2
   } uvp_op_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_FETCH = 4'h1,
      S_SETUP = 4'h2,
      S_PULSE = 4'h3,
      S_HOLD = 4'h4,
      S_READ = 4'h5,
      S_FLOAT = 4'h6,
      S_LOWER = 4'h7,
      S_FINISH = 4'h8
   } uvp_state_t;
endpackage : uvp_pkg

/* File: uvp_tmr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface uvp_tmr_if import uvp_pkg::*; ();
   logic start;
   logic [LEN_W-1:0] len_us;
   logic done;
   modport ctl(output start, output len_us, input done);
   modport tmr(input start, input len_us, output done);
endinterface : uvp_tmr_if
`default_nettype wire

/* File: uvp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module uvp_sync #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : uvp_sync
`default_nettype wire

/* File: uvp_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module uvp_timer import uvp_pkg::*; #(
   parameter int TICK = TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   uvp_tmr_if.tmr tif
);
   localparam int DW = $clog2(TICK + 1);
   logic [DW-1:0] div_q;
   logic [LEN_W-1:0] cnt_q;
   logic run_q;
   logic tick;

   // Divider starts at one so a run lasts exactly len times TICK cycles
   assign tick = run_q && (div_q == DW'(TICK - 1));
   assign tif.done = tick && (cnt_q == tif.len_us - LEN_W'(1));

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_q <= '0;
      end else if (tif.start) begin
         div_q <= DW'(1);
      end else if (run_q) begin
         div_q <= tick ? '0 : div_q + DW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_q <= 1'b0;
         cnt_q <= '0;
      end else if (tif.start) begin
         run_q <= 1'b1;
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + LEN_W'(1);
         if (tif.done) begin
            run_q <= 1'b0;
         end
      end
   end
endmodule : uvp_timer
`default_nettype wire

/* File: uvp_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Put address out and raise supply to programming level before any pulse.
// - First strobe pulse lasts one millisecond, then the byte is read back.
// - A byte passing on its first verify gets one three-millisecond overprogram pulse.
// - Failing bytes get further one-millisecond pulses, at most 25, each verified.
// - Overprogram lasts three times the pulses used, never above 75 ms.
// - Still failing after 25 pulses: stop and report programming failure.
// - Then step to the next address and repeat until the range is done.
// - Lower supply to normal level, read back and compare each byte with source until the first mismatch.
// - Each initial pulse stays within 0.95 to 1.05 milliseconds.
// - Overprogram length lies in 2.85 to 78.75 ms, set by retry count.
// - Identification needs all address lines low except high-voltage and select lines.
module uvp_ctrl import uvp_pkg::*; #(
   parameter int PULSE_US = PULSE_US_DEF,
   parameter int TRIES = MAX_TRIES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic op_start,
   input wire logic [1:0] op_sel,
   input wire logic [ADDR_W-1:0] first_addr,
   input wire logic [ADDR_W-1:0] last_addr,
   output logic src_req_q,
   output logic [ADDR_W-1:0] src_addr_q,
   input wire logic src_valid,
   input wire logic [DATA_W-1:0] src_data,
   output logic busy_q,
   output logic done_q,
   output logic pass_q,
   output logic fail_q,
   output logic [ADDR_W-1:0] fail_addr_q,
   output logic [DATA_W-1:0] id_mfr_q,
   output logic [DATA_W-1:0] id_dev_q,
   output logic [ADDR_W-1:0] addr_q,
   output logic [DATA_W-1:0] dq_out_q,
   output logic dq_oe_n_q,
   input wire logic [DATA_W-1:0] dq_in,
   output logic chip_en_n_q,
   output logic out_en_n_q,
   output logic program_strobe_n_q,
   output logic vcc_prog_q,
   output logic vpp_on_q,
   output logic id_high_voltage_line_q
);
   localparam int PULSE_CYC = PULSE_US * TICK_CYC;

   uvp_state_t st_q;
   uvp_op_t ph_q;
   logic [ADDR_W-1:0] cur_q;
   logic [ADDR_W-1:0] first_q;
   logic [ADDR_W-1:0] last_q;
   logic [DATA_W-1:0] data_q;
   logic [DATA_W-1:0] rd_q;
   logic [DATA_W-1:0] dq_sync;
   logic [TRY_W-1:0] tries_q;
   logic ovp_q;
   logic [CYC_W-1:0] cyc_q;
   logic tmr_start_q;
   logic [LEN_W-1:0] tmr_len_q;
   logic match;
   logic [CNT_W-1:0] sl_cnt_q;

   uvp_tmr_if tif();
   assign tif.start = tmr_start_q;
   assign tif.len_us = tmr_len_q;
   assign match = (rd_q == data_q);

   uvp_timer #(.TICK(TICK_CYC)) u_tmr (
      .core_clk(core_clk),
      .rst(rst),
      .tif(tif.tmr)
   );

   // Data pins come from the device's own drivers
   uvp_sync #(.W(DATA_W)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d(dq_in),
      .q(dq_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge core_clk) begin
      tmr_start_q <= 1'b0;
      src_req_q <= 1'b0;
      done_q <= 1'b0;
      if (rst) begin
         st_q <= S_IDLE;
         ph_q <= OP_PROG;
         cur_q <= '0;
         first_q <= '0;
         last_q <= '0;
         data_q <= '0;
         rd_q <= '0;
         tries_q <= '0;
         ovp_q <= 1'b0;
         cyc_q <= '0;
         tmr_len_q <= '0;
         busy_q <= 1'b0;
         pass_q <= 1'b0;
         fail_q <= 1'b0;
         fail_addr_q <= '0;
         id_mfr_q <= '0;
         id_dev_q <= '0;
         src_addr_q <= '0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (op_start && op_sel != 2'h3) begin
                  ph_q <= uvp_op_t'(op_sel);
                  busy_q <= 1'b1;
                  pass_q <= 1'b0;
                  fail_q <= 1'b0;
                  first_q <= first_addr;
                  last_q <= last_addr;
                  if (uvp_op_t'(op_sel) == OP_ID) begin
                     cur_q <= '0;
                     data_q <= '0;
                     st_q <= S_SETUP;
                     tmr_start_q <= 1'b1;
                     tmr_len_q <= LEN_W'(SETUP_US);
                  end else begin
                     cur_q <= first_addr;
                     src_addr_q <= first_addr;
                     src_req_q <= 1'b1;
                     st_q <= S_FETCH;
                  end
               end
            end
            S_FETCH: begin
               if (src_valid) begin
                  data_q <= src_data;
                  tries_q <= '0;
                  ovp_q <= 1'b0;
                  st_q <= S_SETUP;
                  tmr_start_q <= 1'b1;
                  tmr_len_q <= LEN_W'(SETUP_US);
               end
            end
            S_SETUP: begin
               if (tif.done) begin
                  cyc_q <= '0;
                  if (ph_q == OP_PROG) begin
                     st_q <= S_PULSE;
                     tmr_start_q <= 1'b1;
                     if (ovp_q) begin
                        tmr_len_q <= LEN_W'(OVP_FACTOR * int'(tries_q) * PULSE_US);
                     end else begin
                        tmr_len_q <= LEN_W'(PULSE_US);
                        tries_q <= tries_q + TRY_W'(1);
                     end
                  end else begin
                     st_q <= S_READ;
                  end
               end
            end
            S_PULSE: begin
               if (tif.done) begin
                  st_q <= S_HOLD;
                  tmr_start_q <= 1'b1;
                  tmr_len_q <= LEN_W'(SETUP_US);
               end
            end
            S_HOLD: begin
               if (tif.done) begin
                  cyc_q <= '0;
                  if (!ovp_q) begin
                     st_q <= S_READ;
                  end else if (cur_q == last_q) begin
                     st_q <= S_LOWER;
                     tmr_start_q <= 1'b1;
                     tmr_len_q <= LEN_W'(SETUP_US);
                  end else begin
                     cur_q <= cur_q + ADDR_W'(1);
                     src_addr_q <= cur_q + ADDR_W'(1);
                     src_req_q <= 1'b1;
                     st_q <= S_FETCH;
                  end
               end
            end
            S_READ: begin
               cyc_q <= cyc_q + CYC_W'(1);
               if (cyc_q == CYC_W'(RD_SAMPLE)) begin
                  rd_q <= dq_sync;
                  cyc_q <= '0;
                  st_q <= S_FLOAT;
               end
            end
            S_FLOAT: begin
               cyc_q <= cyc_q + CYC_W'(1);
               if (cyc_q == CYC_W'(FLOAT_CYC - 1)) begin
                  unique case (ph_q)
                     OP_ID: begin
                        if (!cur_q[0]) begin
                           id_mfr_q <= rd_q;
                           cur_q <= ADDR_W'(1);
                           st_q <= S_SETUP;
                           tmr_start_q <= 1'b1;
                           tmr_len_q <= LEN_W'(SETUP_US);
                        end else begin
                           id_dev_q <= rd_q;
                           st_q <= S_FINISH;
                        end
                     end
                     OP_CMP: begin
                        if (!match) begin
                           fail_q <= 1'b1;
                           fail_addr_q <= cur_q;
                           st_q <= S_FINISH;
                        end else if (cur_q == last_q) begin
                           st_q <= S_FINISH;
                        end else begin
                           cur_q <= cur_q + ADDR_W'(1);
                           src_addr_q <= cur_q + ADDR_W'(1);
                           src_req_q <= 1'b1;
                           st_q <= S_FETCH;
                        end
                     end
                     default: begin
                        tmr_start_q <= 1'b1;
                        tmr_len_q <= LEN_W'(SETUP_US);
                        if (match) begin
                           ovp_q <= 1'b1;
                           st_q <= S_SETUP;
                        end else if (int'(tries_q) >= TRIES) begin
                           fail_q <= 1'b1;
                           fail_addr_q <= cur_q;
                           st_q <= S_LOWER;
                        end else begin
                           st_q <= S_SETUP;
                        end
                     end
                  endcase
               end
            end
            S_LOWER: begin
               if (tif.done) begin
                  if (fail_q) begin
                     st_q <= S_FINISH;
                  end else begin
                     ph_q <= OP_CMP;
                     cur_q <= first_q;
                     src_addr_q <= first_q;
                     src_req_q <= 1'b1;
                     st_q <= S_FETCH;
                  end
               end
            end
            S_FINISH: begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               pass_q <= !fail_q;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins follow state one cycle later, so pulse widths stay exact
   always_ff @(posedge core_clk) begin
      if (rst) begin
         chip_en_n_q <= 1'b1;
         out_en_n_q <= 1'b1;
         program_strobe_n_q <= 1'b1;
         dq_oe_n_q <= 1'b1;
         vcc_prog_q <= 1'b0;
         vpp_on_q <= 1'b0;
         id_high_voltage_line_q <= 1'b0;
         addr_q <= '0;
         dq_out_q <= '0;
      end else begin
         chip_en_n_q <= (st_q == S_IDLE) || (st_q == S_FINISH);
         program_strobe_n_q <= (st_q != S_PULSE);
         out_en_n_q <= (st_q != S_READ);
         dq_oe_n_q <= !(ph_q == OP_PROG &&
                        (st_q == S_SETUP || st_q == S_PULSE || st_q == S_HOLD));
         vcc_prog_q <= (ph_q == OP_PROG) && (st_q != S_IDLE) && (st_q != S_FINISH) &&
                       (st_q != S_LOWER);
         vpp_on_q <= (ph_q == OP_PROG) && (st_q != S_IDLE) && (st_q != S_FINISH) &&
                     (st_q != S_LOWER);
         id_high_voltage_line_q <= (ph_q == OP_ID) && (st_q != S_IDLE) &&
                                   (st_q != S_FINISH);
         addr_q <= cur_q;
         dq_out_q <= data_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe low-time counter, read only by checks
   always_ff @(posedge core_clk) begin
      if (rst || program_strobe_n_q) begin
         sl_cnt_q <= '0;
      end else begin
         sl_cnt_q <= sl_cnt_q + CNT_W'(1);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   AST_INIT_PULSE: assert property ($rose(program_strobe_n_q) && !ovp_q |->
      sl_cnt_q == CNT_W'(PULSE_CYC)) else $error("initial pulse width wrong");
   AST_OVP_PULSE: assert property ($rose(program_strobe_n_q) && ovp_q |->
      sl_cnt_q == CNT_W'(OVP_FACTOR * int'(tries_q) * PULSE_CYC))
      else $error("overprogram width wrong");
   AST_STROBE_PINS: assert property (!program_strobe_n_q |->
      !chip_en_n_q && out_en_n_q && !dq_oe_n_q) else $error("pins wrong in pulse");
   AST_PROG_SUPPLY: assert property (!program_strobe_n_q |->
      vcc_prog_q && vpp_on_q) else $error("pulse without programming supply");
   AST_TRY_CAP: assert property (int'(tries_q) <= TRIES)
      else $error("too many pulses");
   AST_VERIFY_AFTER: assert property ($rose(program_strobe_n_q) && !ovp_q |->
      ##[1:120] !out_en_n_q) else $error("no verify after pulse");
   AST_FAIL_STOP: assert property ($rose(fail_q) && ph_q == OP_PROG |->
      int'(tries_q) == TRIES) else $error("failed before last try");
   AST_CMP_LOW: assert property (!out_en_n_q && ph_q == OP_CMP |->
      !vcc_prog_q && !vpp_on_q) else $error("compare at programming supply");
   AST_ID_ADDR: assert property (id_high_voltage_line_q |->
      addr_q[ADDR_W-1:1] == '0) else $error("id read with upper address set");
   AST_FLOAT_GAP: assert property ($rose(out_en_n_q) |-> dq_oe_n_q [*6])
      else $error("drove data before float");
   AST_NEXT_ADDR: assert property (src_req_q && ph_q == OP_PROG && $past(ovp_q) |->
      src_addr_q == $past(cur_q) + ADDR_W'(1)) else $error("bad next address");

   COV_FAIL: cover property ($rose(fail_q));
   COV_RETRY: cover property ($rose(program_strobe_n_q) && ovp_q && tries_q > TRY_W'(1));
   COV_ID: cover property (done_q && ph_q == OP_ID);
   COV_PASS: cover property (done_q && pass_q && ph_q == OP_CMP);
endmodule : uvp_ctrl
`default_nettype wire

/* File: uvp_eprom_mdl.sv */
`timescale 1ns/10ps
`default_nettype none
module uvp_eprom_mdl import uvp_pkg::*; #(
   parameter int UNIT_NS = 1000000,
   parameter int TRIES = MAX_TRIES,
   // Arbitrary identification values
   parameter logic [7:0] MFR_CODE = 8'h5a,
   parameter logic [7:0] DEV_CODE = 8'hc3,
   parameter int ACC_NS = 120,
   parameter int REL_NS = 50
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   output logic [DATA_W-1:0] dq_in,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic program_strobe_n,
   input wire logic vcc_prog,
   input wire logic vpp_on,
   input wire logic id_high_voltage_line
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   int need [2**ADDR_W];
   int pulses [2**ADDR_W];
   int ovp [2**ADDR_W];
   int viol = 0;
   int gen = 0;
   logic drv = 1'b0;
   logic pend = 1'b0;
   logic armed = 1'b0;
   logic en;
   logic [DATA_W-1:0] last = 8'h00;
   logic [DATA_W-1:0] rd_val;
   realtime t_fall;
   real w;
   real k;

   initial begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
         mem[i] = 8'hff;
         need[i] = 1;
         pulses[i] = 0;
         ovp[i] = 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign en = (chip_en_n === 1'b0) && (out_en_n === 1'b0);
   assign rd_val = id_high_voltage_line ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr];

   always @(addr or en or id_high_voltage_line) begin
      gen = gen + 1;
      if (en) drv = 1'b0;
      fork
         settle(gen);
      join_none
   end

   task automatic settle(input int g);
      if (en) #(ACC_NS);
      else #(REL_NS);
      if (g == gen) drv = en;
   endtask : settle

   // Released pins show the inverse so stale data never looks valid
   always @(negedge drv) last = rd_val;
   always @* begin
      if (dq_oe_n === 1'b0) dq_in = dq_out;
      else if (drv) dq_in = rd_val;
      else dq_in = ~last;
   end

   always @(dq_oe_n or drv) begin
      if (dq_oe_n === 1'b0 && drv) viol = viol + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(negedge out_en_n) begin
      pend = 1'b0;
      if (vpp_on === 1'b0 && vcc_prog !== 1'b0) viol = viol + 1;
      if (id_high_voltage_line === 1'b1 && addr[ADDR_W-1:1] !== '0) viol = viol + 1;
   end

   always @(negedge program_strobe_n) begin
      armed = 1'b1;
      t_fall = $realtime;
      if (chip_en_n !== 1'b0 || out_en_n !== 1'b1 || dq_oe_n !== 1'b0) viol = viol + 1;
      if (vcc_prog !== 1'b1 || vpp_on !== 1'b1 || pend) viol = viol + 1;
   end

   always @(posedge program_strobe_n) begin
      if (armed) begin
         w = ($realtime - t_fall) / UNIT_NS;
         k = OVP_FACTOR * ((pulses[addr] > MAX_TRIES) ? MAX_TRIES : pulses[addr]);
         if (w > 0.95 && w < 1.05) begin
            if (pulses[addr] >= TRIES || ovp[addr] != 0) viol = viol + 1;
            pulses[addr] = pulses[addr] + 1;
            pend = 1'b1;
            if (pulses[addr] >= need[addr]) mem[addr] = mem[addr] & dq_out;
         end else begin
            if (w < 0.95 * k || w > 1.05 * k || mem[addr] !== dq_out) viol = viol + 1;
            ovp[addr] = ovp[addr] + 1;
         end
      end
   end
endmodule : uvp_eprom_mdl
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import uvp_pkg::*; ;
   // Shortened pulse unit keeps the run to about two thousand cycles per byte at most
   localparam int PUS = 3;
   localparam int TR = 3;
   // Arbitrary identification values
   localparam logic [7:0] MFR = 8'h5a;
   localparam logic [7:0] DEV = 8'hc3;
   logic core_clk, rst, op_start, src_valid;
   logic [1:0] op_sel;
   logic [ADDR_W-1:0] first_addr, last_addr, src_addr_q, fail_addr_q, addr_q;
   logic [DATA_W-1:0] src_data, id_mfr_q, id_dev_q, dq_out_q, dq_in;
   logic src_req_q, busy_q, done_q, pass_q, fail_q, dq_oe_n_q, chip_en_n_q;
   logic out_en_n_q, program_strobe_n_q, vcc_prog_q, vpp_on_q, id_high_voltage_line_q;
   logic [DATA_W-1:0] src [2**ADDR_W];
   int n_errors = 0;
   int checked = 0;

   uvp_ctrl #(.PULSE_US(PUS), .TRIES(TR)) dut (.core_clk(core_clk), .rst(rst),
      .op_start(op_start), .op_sel(op_sel), .first_addr(first_addr),
      .last_addr(last_addr), .src_req_q(src_req_q), .src_addr_q(src_addr_q),
      .src_valid(src_valid), .src_data(src_data), .busy_q(busy_q), .done_q(done_q),
      .pass_q(pass_q), .fail_q(fail_q), .fail_addr_q(fail_addr_q), .id_mfr_q(id_mfr_q),
      .id_dev_q(id_dev_q), .addr_q(addr_q), .dq_out_q(dq_out_q), .dq_oe_n_q(dq_oe_n_q),
      .dq_in(dq_in), .chip_en_n_q(chip_en_n_q), .out_en_n_q(out_en_n_q),
      .program_strobe_n_q(program_strobe_n_q), .vcc_prog_q(vcc_prog_q),
      .vpp_on_q(vpp_on_q), .id_high_voltage_line_q(id_high_voltage_line_q));

   uvp_eprom_mdl #(.UNIT_NS(PUS * 1000), .TRIES(TR), .MFR_CODE(MFR), .DEV_CODE(DEV)) mdl (
      .addr(addr_q), .dq_out(dq_out_q), .dq_oe_n(dq_oe_n_q), .dq_in(dq_in),
      .chip_en_n(chip_en_n_q), .out_en_n(out_en_n_q),
      .program_strobe_n(program_strobe_n_q), .vcc_prog(vcc_prog_q), .vpp_on(vpp_on_q),
      .id_high_voltage_line(id_high_voltage_line_q));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic complete_run();
      if (n_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      #1000000;
      n_errors++;
      complete_run();
   end

   // Source answers each request after a random stall
   initial begin
      src_valid = 1'b0;
      src_data = 8'h00;
      forever begin
         @(posedge core_clk);
         #2;
         if (src_req_q === 1'b1) begin
            repeat ($urandom_range(2, 0)) begin
               @(posedge core_clk);
               #2;
            end
            src_valid = 1'b1;
            src_data = src[src_addr_q];
            @(posedge core_clk);
            #2;
            src_valid = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic run_op(input logic [1:0] sel, input int fa, input int la);
      int n;
      op_sel = sel;
      first_addr = ADDR_W'(fa);
      last_addr = ADDR_W'(la);
      op_start = 1'b1;
      @(posedge core_clk);
      #2;
      op_start = 1'b0;
      chk(busy_q, 1'b1);
      n = 0;
      while (done_q !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         #2;
         n++;
      end
      chk(done_q, 1'b1);
   endtask : run_op

   task automatic prog_case(input int fa, input int la, input int bad);
      int a;
      for (a = fa; a <= la; a++) begin
         src[a] = 8'($urandom_range(254, 0));
         mdl.need[a] = (a == bad) ? TR + 1 : (a == fa) ? 1 : (a == la) ? TR : $urandom_range(TR, 1);
      end
      run_op(2'h0, fa, la);
      chk(pass_q, bad < 0);
      chk(fail_q, bad >= 0);
      if (bad >= 0) chk(fail_addr_q, bad);
      for (a = fa; a <= la; a++) begin
         if (bad < 0 || a < bad) begin
            chk(mdl.pulses[a], mdl.need[a]);
            chk(mdl.ovp[a], 1);
            chk(mdl.mem[a], src[a]);
         end else begin
            chk(mdl.pulses[a], (a == bad) ? TR : 0);
            chk(mdl.ovp[a], 0);
         end
      end
   endtask : prog_case

   initial begin
      void'($urandom(32'h4e56));
      rst = 1'b1;
      op_start = 1'b0;
      op_sel = 2'h0;
      first_addr = '0;
      last_addr = '0;
      repeat (16) @(posedge core_clk);
      #2;
      rst = 1'b0;
      chk({chip_en_n_q, out_en_n_q, program_strobe_n_q, dq_oe_n_q}, 4'hf);
      chk({vcc_prog_q, vpp_on_q, busy_q, fail_q}, 4'h0);
      @(posedge core_clk);
      #2;
      // Unused code must not start anything
      op_sel = 2'h3;
      op_start = 1'b1;
      @(posedge core_clk);
      #2;
      op_start = 1'b0;
      repeat (4) @(posedge core_clk);
      #2;
      chk(busy_q, 1'b0);
      prog_case(16'h10, 16'h15, -1);
      run_op(2'h1, 16'h10, 16'h15);
      chk({pass_q, fail_q}, 2'h2);
      mdl.mem[16'h13] = mdl.mem[16'h13] ^ 8'h10;
      mdl.mem[16'h14] = mdl.mem[16'h14] ^ 8'h01;
      run_op(2'h1, 16'h10, 16'h15);
      chk({pass_q, fail_q}, 2'h1);
      chk(fail_addr_q, 16'h13);
      prog_case(16'h3ffc, 16'h3fff, 16'h3ffe);
      run_op(2'h2, 0, 0);
      chk(id_mfr_q, MFR);
      chk(id_dev_q, DEV);
      chk(mdl.viol, 0);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
